// >>> core/pts_pkg.sv
// Constants and types shared by the programmable threshold stage
package pts_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PROG_CYCLE_NS  = 1000000;
    localparam int PROG_CYCLE_CLK = PROG_CYCLE_NS / CLK_PERIOD_NS;
    localparam int WINDOW_MS      = 20;
    localparam int WINDOW_TICKS   = WINDOW_MS * PROG_CYCLE_NS / PROG_CYCLE_NS;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int MEAS_W   = 32;
    localparam int HYST_W   = 20;
    localparam int DLY_W    = 21;
    localparam int TIME_W   = 40;
    localparam int CNT_W    = 32;
    localparam int NUM_MEAS = 3;
    localparam int LOG_N    = 12;
    localparam int LOG_AW   = 4;
    localparam int SG_W     = 3;
    localparam int EVT_W    = 2;
    localparam int RATIO_FB = 8;

    // ------------------------------------------------------------
    // Settings and reset values
    // ------------------------------------------------------------
    localparam logic [DLY_W-1:0] MAX_DLY_MS    = 21'h1b7740;
    localparam logic [HYST_W-1:0] HYST_DEFAULT = 20'h07530;
    localparam logic [HYST_W:0] HYST_DENOM     = 21'h0f4240;
    localparam logic [7:0] PCT_SCALE           = 8'h64;

    // Log record layout: time, event, measurement, ratio, remaining, group
    localparam int REC_W = TIME_W + EVT_W + MEAS_W + MEAS_W + DLY_W + SG_W;

    // Event identities in the log
    localparam logic [EVT_W-1:0] EVT_START   = 2'h0;
    localparam logic [EVT_W-1:0] EVT_TRIP    = 2'h1;
    localparam logic [EVT_W-1:0] EVT_BLOCKED = 2'h2;

    // Event vector bit positions
    localparam int EV_START_ON  = 0;
    localparam int EV_START_OFF = 1;
    localparam int EV_TRIP_ON   = 2;
    localparam int EV_TRIP_OFF  = 3;
    localparam int EV_BLOCK_ON  = 4;
    localparam int EV_BLOCK_OFF = 5;
    localparam int EV_N         = 6;

    typedef enum logic [2:0] {
        PTS_OVER      = 3'h0,
        PTS_OVER_ABS  = 3'h1,
        PTS_UNDER     = 3'h2,
        PTS_UNDER_ABS = 3'h3,
        PTS_REL_SGN   = 3'h4,
        PTS_REL_ABS   = 3'h5,
        PTS_DLT_SGN   = 3'h6,
        PTS_DLT_ABS   = 3'h7
    } pts_mode_t;

    typedef enum logic [3:0] {
        PTS_IDLE    = 4'h1,
        PTS_RUN     = 4'h2,
        PTS_TRIPPED = 4'h4,
        PTS_RELEASE = 4'h8
    } pts_state_t;

endpackage

// >>> core/pts_compare.sv
// One comparator channel with hysteresis and a 20 ms change window
`timescale 1ns/10ps
module pts_compare (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    // Timing enables
    input  wire logic                         eval,
    input  wire logic                         win,
    // Settings
    input  wire pts_pkg::pts_mode_t           mode,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] pick,
    input  wire logic [pts_pkg::HYST_W-1:0]   hyst,
    input  wire logic                         blk_lim_en,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] blk_lim,
    // Sample and result
    input  wire logic signed [pts_pkg::MEAS_W-1:0] meas,
    output logic                              cond
);
    logic signed [pts_pkg::MEAS_W-1:0] win_ref;
    logic                              ref_ok;
    logic signed [63:0] x, ref64, p64, dlt, a, b, lvl, e;
    logic signed [95:0] lhs, rhs;
    logic               greater, is_delta, lim_block;

    // Reference sample, renewed once per window
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            win_ref <= '0;
            ref_ok  <= 1'b0;
        end else if (win) begin
            win_ref <= meas;
            ref_ok  <= 1'b1;
        end
    end

    always_comb begin
        x       = 64'(meas);
        ref64   = 64'(win_ref);
        p64     = 64'(pick);
        dlt     = x - ref64;
        greater = 1'b1;
        a       = x;
        b       = p64;
        case (mode)
            pts_pkg::PTS_OVER: a = x;
            pts_pkg::PTS_OVER_ABS: a = (x < 0) ? -x : x;
            pts_pkg::PTS_UNDER: greater = 1'b0;
            pts_pkg::PTS_UNDER_ABS: begin
                a       = (x < 0) ? -x : x;
                greater = 1'b0;
            end
            pts_pkg::PTS_REL_SGN: begin
                a       = dlt * 64'(pts_pkg::PCT_SCALE);
                b       = p64 * ((ref64 < 0) ? -ref64 : ref64);
                greater = (p64 >= 0);
            end
            pts_pkg::PTS_REL_ABS: begin
                a = ((dlt < 0) ? -dlt : dlt) * 64'(pts_pkg::PCT_SCALE);
                b = ((p64 < 0) ? -p64 : p64) * ((ref64 < 0) ? -ref64 : ref64);
            end
            pts_pkg::PTS_DLT_SGN: begin
                a       = dlt;
                greater = (p64 >= 0);
            end
            default: begin
                a = (dlt < 0) ? -dlt : dlt;
                b = (p64 < 0) ? -p64 : p64;
            end
        endcase
        is_delta  = mode[2];
        lim_block = blk_lim_en && !is_delta && mode[1] && (x < 64'(blk_lim));
        e   = greater ? (a - b) : (b - a);
        lvl = (b < 0) ? -b : b;
        // Hysteresis relative to the level, widens the band once picked up
        lhs = 96'(e) * 96'(pts_pkg::HYST_DENOM);
        rhs = cond ? -(96'(lvl) * 96'(hyst)) : 96'sh0;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cond <= 1'b0;
        end else if (eval) begin
            cond <= (lhs > rhs) && !lim_block && (ref_ok || !is_delta);
        end
    end
endmodule // pts_compare

// >>> core/pts_logmem.sv
// Twelve-entry record store with registered read data
`timescale 1ns/10ps
module pts_logmem (
    // Clock
    input  wire logic                         ref_clk,
    // Write port
    input  wire logic                         wr_en,
    input  wire logic [pts_pkg::LOG_AW-1:0]   wr_addr,
    input  wire logic [pts_pkg::REC_W-1:0]    wr_data,
    // Read port
    input  wire logic [pts_pkg::LOG_AW-1:0]   rd_addr,
    output logic [pts_pkg::REC_W-1:0]         rd_data
);
    logic [pts_pkg::REC_W-1:0] mem [pts_pkg::LOG_N];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Out of range read returns zero
    always_ff @(posedge ref_clk) begin
        if (rd_addr < pts_pkg::LOG_AW'(pts_pkg::LOG_N)) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule // pts_logmem

// >>> core/pts_stage.sv
// Programmable threshold stage: comparators, timers, events, counters, log
//
// Functional notes
// - Signed over mode: true when measurement exceeds pick-up level.
// - Absolute over mode: true when magnitude exceeds pick-up level.
// - Signed under mode: true when measurement is below pick-up level.
// - Absolute under mode: true when magnitude is below pick-up level.
// - Under modes: optional blocking limit forces false below that limit.
// - Signed relative change over percentage within 20 ms, in set direction.
// - Absolute relative change over percentage within 20 ms, either direction.
// - Signed change over pick-up value within 20 ms, in set direction.
// - Absolute change over pick-up value within 20 ms, either direction.
// - Each comparison has its own signed pick-up level.
// - Each level has its own release hysteresis, default three percent.
// - Configurable operating and release delays per stage.
// - Blocking input sampled at start of each evaluation cycle.
// - Pick-up while unblocked asserts start and runs operate timing.
// - Pick-up while blocked asserts blocked, no timing or trip.
// - Blocking during start resets start and runs release processing.
// - Time-stamped ON/OFF events, per-event selection of storage.
// - Clearable cumulative counters for start, trip and blocked.
// - Circular log of the last twelve time-stamped records.
// - Log written on ON of start, trip, blocked with full data.
// - One event per rising and falling edge of start, trip, block.
// - One, two or three measurements evaluated, each own comparison.
// - Hysteresis is relative to the pick-up value.
`timescale 1ns/10ps
module pts_stage #(
    parameter int TICK_CYCLES = pts_pkg::PROG_CYCLE_CLK
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // Measurements
    input  wire logic signed [pts_pkg::MEAS_W-1:0] meas_0,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] meas_1,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] meas_2,
    // Comparator settings
    input  wire logic [1:0]                    meas_used,
    input  wire pts_pkg::pts_mode_t            mode_0,
    input  wire pts_pkg::pts_mode_t            mode_1,
    input  wire pts_pkg::pts_mode_t            mode_2,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] pick_0,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] pick_1,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] pick_2,
    input  wire logic [pts_pkg::HYST_W-1:0]    hyst_0,
    input  wire logic [pts_pkg::HYST_W-1:0]    hyst_1,
    input  wire logic [pts_pkg::HYST_W-1:0]    hyst_2,
    input  wire logic [pts_pkg::NUM_MEAS-1:0]  blk_lim_en,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] blk_lim_0,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] blk_lim_1,
    input  wire logic signed [pts_pkg::MEAS_W-1:0] blk_lim_2,
    // Stage timing settings, in milliseconds
    input  wire logic [pts_pkg::DLY_W-1:0]     op_delay,
    input  wire logic [pts_pkg::DLY_W-1:0]     rel_delay,
    // Blocking and context
    input  wire logic                          block_in,
    input  wire logic [pts_pkg::SG_W-1:0]      setting_group,
    // Events
    input  wire logic [pts_pkg::EV_N-1:0]      ev_select,
    output logic [pts_pkg::EV_N-1:0]           ev_pulse,
    output logic [pts_pkg::EV_N-1:0]           ev_store,
    output logic [pts_pkg::TIME_W-1:0]         time_ms,
    // Stage outputs
    output logic                               start,
    output logic                               trip,
    output logic                               blocked,
    output logic [pts_pkg::DLY_W-1:0]          time_left,
    // Counters
    input  wire logic [2:0]                    cnt_clear,
    output logic [pts_pkg::CNT_W-1:0]          cnt_start,
    output logic [pts_pkg::CNT_W-1:0]          cnt_trip,
    output logic [pts_pkg::CNT_W-1:0]          cnt_blocked,
    // Log access
    input  wire logic [pts_pkg::LOG_AW-1:0]    log_rd_addr,
    output logic [pts_pkg::REC_W-1:0]          log_rd_data,
    output logic [pts_pkg::LOG_AW-1:0]         log_wr_ptr,
    output logic [pts_pkg::LOG_AW-1:0]         log_count
);
    // ------------------------------------------------------------
    // Program cycle and window enables
    // ------------------------------------------------------------
    logic [31:0] div_cnt;
    logic [7:0]  win_cnt;
    logic        tick;
    logic        win;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else if (div_cnt == 32'(TICK_CYCLES - 1)) begin
            div_cnt <= '0;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 32'h1;
            tick    <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            win_cnt <= '0;
            win     <= 1'b0;
        end else begin
            win <= 1'b0;
            if (tick) begin
                if (win_cnt == 8'(pts_pkg::WINDOW_TICKS - 1)) begin
                    win_cnt <= '0;
                    win     <= 1'b1;
                end else begin
                    win_cnt <= win_cnt + 8'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            time_ms <= '0;
        end else if (tick) begin
            time_ms <= time_ms + 40'h1;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    logic [pts_pkg::NUM_MEAS-1:0] cond;
    logic signed [pts_pkg::MEAS_W-1:0] meas_v [pts_pkg::NUM_MEAS];
    logic signed [pts_pkg::MEAS_W-1:0] pick_v [pts_pkg::NUM_MEAS];
    logic signed [pts_pkg::MEAS_W-1:0] lim_v [pts_pkg::NUM_MEAS];
    logic [pts_pkg::HYST_W-1:0] hyst_v [pts_pkg::NUM_MEAS];
    pts_pkg::pts_mode_t mode_v [pts_pkg::NUM_MEAS];

    assign meas_v = '{meas_0, meas_1, meas_2};
    assign pick_v = '{pick_0, pick_1, pick_2};
    assign lim_v  = '{blk_lim_0, blk_lim_1, blk_lim_2};
    assign hyst_v = '{hyst_0, hyst_1, hyst_2};
    assign mode_v = '{mode_0, mode_1, mode_2};

    for (genvar i = 0; i < pts_pkg::NUM_MEAS; i++) begin : g_cmp
        pts_compare u_cmp (
            .ref_clk    (ref_clk),
            .reset      (reset),
            .eval       (tick),
            .win        (win),
            .mode       (mode_v[i]),
            .pick       (pick_v[i]),
            .hyst       (hyst_v[i]),
            .blk_lim_en (blk_lim_en[i]),
            .blk_lim    (lim_v[i]),
            .meas       (meas_v[i]),
            .cond       (cond[i])
        );
    end

    // Channels 1 and 2 count only when enabled by the used-count setting, channel 0 always counts
    logic pickup;
    logic eval_d;
    assign pickup = cond[0]
                  | (cond[1] & (meas_used >= 2'h2))
                  | (cond[2] & (meas_used == 2'h3));

    // Stage logic runs the cycle after comparators settle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            eval_d <= 1'b0;
        end else begin
            eval_d <= tick;
        end
    end

    // ------------------------------------------------------------
    // Stage state machine
    // ------------------------------------------------------------
    pts_pkg::pts_state_t state;
    logic [pts_pkg::DLY_W-1:0] op_cnt;
    logic [pts_pkg::DLY_W-1:0] rel_cnt;
    logic blk_s;
    logic act;

    // Blocking source is used directly, read at every stage evaluation edge in every state
    assign blk_s = block_in;
    assign act   = pickup & ~blk_s;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state   <= pts_pkg::PTS_IDLE;
            op_cnt  <= '0;
            rel_cnt <= '0;
            trip    <= 1'b0;
        end else if (eval_d) begin
            case (state)
                pts_pkg::PTS_IDLE: begin
                    op_cnt <= '0;
                    if (act) begin
                        state <= pts_pkg::PTS_RUN;
                        if (op_delay <= 21'h1) begin
                            state <= pts_pkg::PTS_TRIPPED;
                            trip  <= 1'b1;
                        end
                        op_cnt <= 21'h1;
                    end
                end
                pts_pkg::PTS_RUN: begin
                    if (!act) begin
                        state   <= pts_pkg::PTS_RELEASE;
                        rel_cnt <= '0;
                    end else if (op_cnt + 21'h1 >= op_delay) begin
                        state  <= pts_pkg::PTS_TRIPPED;
                        trip   <= 1'b1;
                        op_cnt <= op_delay;
                    end else begin
                        op_cnt <= op_cnt + 21'h1;
                    end
                end
                pts_pkg::PTS_TRIPPED: begin
                    if (!act) begin
                        state   <= pts_pkg::PTS_RELEASE;
                        rel_cnt <= '0;
                    end
                end
                pts_pkg::PTS_RELEASE: begin
                    if (act) begin
                        state <= trip ? pts_pkg::PTS_TRIPPED : pts_pkg::PTS_RUN;
                    end else if (rel_cnt + 21'h1 >= rel_delay) begin
                        state  <= pts_pkg::PTS_IDLE;
                        trip   <= 1'b0;
                        op_cnt <= '0;
                    end else begin
                        rel_cnt <= rel_cnt + 21'h1;
                    end
                end
                default: state <= pts_pkg::PTS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            start     <= 1'b0;
            blocked   <= 1'b0;
            time_left <= '0;
        end else begin
            start     <= (state == pts_pkg::PTS_RUN) || (state == pts_pkg::PTS_TRIPPED);
            time_left <= (state == pts_pkg::PTS_RUN) ? op_delay - op_cnt : '0;
            if (eval_d) begin
                blocked <= pickup & blk_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    logic start_q, trip_q, blocked_q;
    logic [pts_pkg::EV_N-1:0] ev_now;

    assign ev_now = {~blocked & blocked_q, blocked & ~blocked_q,
                     ~trip & trip_q, trip & ~trip_q,
                     ~start & start_q, start & ~start_q};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            start_q   <= 1'b0;
            trip_q    <= 1'b0;
            blocked_q <= 1'b0;
            ev_pulse  <= '0;
            ev_store  <= '0;
        end else begin
            start_q   <= start;
            trip_q    <= trip;
            blocked_q <= blocked;
            ev_pulse  <= ev_now;
            ev_store  <= ev_now & ev_select;
        end
    end

    // ------------------------------------------------------------
    // Counters, an increment with a same-cycle clear loads one
    // ------------------------------------------------------------
    logic [pts_pkg::CNT_W-1:0] cnt_q [3];
    logic [2:0] on_ev;
    assign on_ev = {ev_now[pts_pkg::EV_BLOCK_ON], ev_now[pts_pkg::EV_TRIP_ON],
                    ev_now[pts_pkg::EV_START_ON]};

    for (genvar k = 0; k < 3; k++) begin : g_cnt
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cnt_q[k] <= '0;
            end else if (on_ev[k]) begin
                cnt_q[k] <= cnt_clear[k] ? 32'h1 : cnt_q[k] + 32'h1;
            end else if (cnt_clear[k]) begin
                cnt_q[k] <= '0;
            end
        end
    end
    assign cnt_start   = cnt_q[0];
    assign cnt_trip    = cnt_q[1];
    assign cnt_blocked = cnt_q[2];

    // ------------------------------------------------------------
    // Record log, one write per clock from pending ON events
    // ------------------------------------------------------------
    logic [2:0] pend;
    logic [2:0] pend_all;
    logic [pts_pkg::EVT_W-1:0] wr_evt;
    logic [2:0] wr_one;
    logic signed [pts_pkg::MEAS_W-1:0] ratio;
    logic [pts_pkg::REC_W-1:0] rec;

    assign pend_all = pend | on_ev;
    assign wr_one   = pend_all & ~(pend_all - 3'h1);
    assign wr_evt   = wr_one[0] ? pts_pkg::EVT_START :
                      wr_one[1] ? pts_pkg::EVT_TRIP : pts_pkg::EVT_BLOCKED;
    // Ratio in fixed point, zero when the setting is zero
    assign ratio = (pick_0 == 0) ? '0
                 : 32'((64'(meas_0) <<< pts_pkg::RATIO_FB) / 64'(pick_0));
    assign rec = {time_ms, wr_evt, meas_0, ratio, time_left, setting_group};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pend       <= '0;
            log_wr_ptr <= '0;
            log_count  <= '0;
        end else begin
            pend <= pend_all & ~wr_one;
            if (|pend_all) begin
                log_wr_ptr <= (log_wr_ptr == 4'(pts_pkg::LOG_N - 1)) ? '0
                            : log_wr_ptr + 4'h1;
                if (log_count != 4'(pts_pkg::LOG_N)) begin
                    log_count <= log_count + 4'h1;
                end
            end
        end
    end

    pts_logmem u_log (
        .ref_clk (ref_clk),
        .wr_en   (|pend_all),
        .wr_addr (log_wr_ptr),
        .wr_data (rec),
        .rd_addr (log_rd_addr),
        .rd_data (log_rd_data)
    );
endmodule // pts_stage

// >>> tb/pts_stage_sva.sv
// Port-level properties of the threshold stage
`timescale 1ns/10ps
module pts_stage_sva (
    // Watched ports
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        start,
    input wire logic        trip,
    input wire logic        blocked,
    input wire logic [5:0]  ev_pulse,
    input wire logic [5:0]  ev_store,
    input wire logic [5:0]  ev_select,
    input wire logic [2:0]  cnt_clear,
    input wire logic [31:0] cnt_start,
    input wire logic [31:0] cnt_trip,
    input wire logic [3:0]  log_count
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_start_on_event: assert property ($rose(start) |=> ev_pulse[0])
        else $error("start rise without event");
    chk_trip_on_event: assert property ($rose(trip) |=> ev_pulse[2])
        else $error("trip rise without event");
    chk_block_on_event: assert property ($rose(blocked) |=> ev_pulse[4])
        else $error("blocked rise without event");
    chk_event_store: assert property ($rose(start) && ev_select[0] |-> ##[1:2] ev_store[0])
        else $error("selected event not stored");
    chk_start_count: assert property (ev_pulse[0] && !$past(cnt_clear[0]) |-> cnt_start == $past(cnt_start) + 32'h1)
        else $error("start counter not advanced");
    chk_trip_clear: assert property ($past(cnt_clear[1]) && !ev_pulse[2] |-> cnt_trip == 32'h0)
        else $error("trip counter not cleared");
    chk_block_drops: assert property ($rose(blocked) |-> ##[0:2] !start)
        else $error("start kept while blocked");
    chk_log_depth: assert property (log_count <= 4'hc)
        else $error("log count beyond depth");
endmodule // pts_stage_sva
bind pts_stage pts_stage_sva u_sva (.ref_clk, .reset, .start, .trip, .blocked, .ev_pulse,
    .ev_store, .ev_select, .cnt_clear, .cnt_start, .cnt_trip, .log_count);

// >>> tb/pts_front.sv
// Measurement front end and blocking matrix model
`timescale 1ns/10ps
module pts_front (
    // Commands from the bench
    input  wire logic               ref_clk,
    input  wire logic signed [31:0] want_meas,
    input  wire logic               want_blk,
    // Stage side
    output logic signed [31:0]      meas = 32'h0,
    output logic                    blk = 1'h0
);
    // Same-clock levels, changed only at an edge as the matrix does
    always_ff @(posedge ref_clk) begin
        meas <= want_meas;
        blk  <= want_blk;
    end
endmodule // pts_front

// >>> tb/pts_stage_tb_top.sv
// Directed bench for the programmable threshold stage
`timescale 1ns/10ps
module pts_stage_tb_top;
    localparam int TC = 20;
    logic ref_clk = 0, reset = 1, want_blk = 0, block_in, start, trip, blocked;
    logic signed [31:0] want_meas = 32'h0, meas_0, pick_0 = 32'h64, blk_lim = -32'sh3e8;
    logic [1:0] meas_used = 2'h1;
    logic [19:0] hyst = 20'h07530;
    logic [20:0] time_left;
    logic [3:0] log_rd_addr = 4'h0, log_wr_ptr, log_count;
    pts_pkg::pts_mode_t mode_0 = pts_pkg::PTS_OVER;
    logic [20:0] op_delay = 21'h3;
    logic [2:0] cnt_clear = 3'h0;
    logic [31:0] cnt_start, cnt_blocked, cnt_trip;
    logic [129:0] rec;
    // Change modes measure against the 20 ms reference latched during entry 3
    logic [2:0] md[10] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h0, 3'h6, 3'h6, 3'h7, 3'h5, 3'h4};
    logic signed [31:0] pk[10] = '{32'h64, 32'h64, 32'h64, 32'h64, -32'sh64,
        32'h64, -32'sh64, 32'h64, 32'h32, -32'sh32};
    logic signed [31:0] ms[10] = '{-32'sh96, 32'h32, -32'sh32, -32'sh7d0, -32'sh32,
        32'h0, 32'h0, 32'h0, 32'h0, -32'shfa0};
    logic ex[10] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1};
    int num_errors = 0, tests_run = 0;
    pts_front front (.ref_clk, .want_meas, .want_blk, .meas(meas_0), .blk(block_in));
    pts_stage #(.TICK_CYCLES(TC)) dut (.ref_clk, .reset, .meas_0, .meas_1(meas_0),
        .meas_2(meas_0), .meas_used, .mode_0, .mode_1(mode_0), .mode_2(mode_0),
        .pick_0, .pick_1(pick_0), .pick_2(pick_0), .hyst_0(hyst), .hyst_1(hyst),
        .hyst_2(hyst), .blk_lim_en(3'h7), .blk_lim_0(blk_lim), .blk_lim_1(blk_lim),
        .blk_lim_2(blk_lim), .op_delay, .rel_delay(21'h2), .block_in, .setting_group(3'h5),
        .ev_select(6'h3f), .ev_pulse(), .ev_store(), .time_ms(), .start, .trip, .blocked,
        .time_left, .cnt_clear, .cnt_start, .cnt_trip, .cnt_blocked,
        .log_rd_addr, .log_rd_data(rec), .log_wr_ptr, .log_count);
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [129:0] got, input logic [129:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    // Whole ticks keep each check mid-tick, at a phase moved one clock later by the counter clear step
    task automatic ticks(input int n);
        repeat (n * TC) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        conclude;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 reset = 0;
        repeat (30) @(posedge ref_clk);
        #1 want_meas = 32'h96;
        ticks(1);
        chk({start, trip, cnt_start, time_left}, {2'h2, 32'h1, 21'h2});
        ticks(1);
        chk(trip, 1'h0);
        ticks(1);
        chk(trip, 1'h1);
        want_meas = 32'h62;
        ticks(1);
        chk(start, 1'h1);
        want_meas = 32'h32;
        ticks(1);
        chk({start, trip}, 2'h1);
        ticks(2);
        chk(trip, 1'h0);
        chk(rec, {40'h2, pts_pkg::EVT_START, 32'h96, 32'h180, 21'h2, 3'h5});
        chk({log_wr_ptr, log_count, cnt_trip}, {8'h22, 32'h1});
        log_rd_addr = 4'h1;
        cnt_clear = 3'h7;
        @(posedge ref_clk);
        #1 cnt_clear = 3'h0;
        chk({cnt_start, cnt_trip}, 64'h0);
        chk(rec, {40'h4, pts_pkg::EVT_TRIP, 32'h96, 32'h180, 21'h1, 3'h5});
        op_delay = 21'h14;
        want_blk = 1;
        want_meas = 32'h96;
        ticks(1);
        chk({start, blocked, cnt_blocked}, {2'h1, 32'h1});
        want_blk = 0;
        ticks(1);
        chk({start, blocked}, 2'h2);
        want_blk = 1;
        ticks(1);
        chk({start, blocked, trip}, 3'h2);
        want_blk = 0;
        want_meas = 32'h0;
        ticks(2);
        for (int i = 0; i < 10; i++) begin
            mode_0 = pts_pkg::pts_mode_t'(md[i]);
            pick_0 = pk[i];
            want_meas = ms[i];
            ticks(1);
            chk(start, ex[i]);
            mode_0 = pts_pkg::PTS_OVER;
            pick_0 = 32'h3e8;
            want_meas = 32'h0;
            ticks(1);
        end
        conclude;
    end
endmodule // pts_stage_tb_top
